// ==== rtl/pcr_pkg.sv ====
// Package for the processor control register group: offsets, fields,
// reset values and carrier types.
// Offsets are word indices; APB byte address is four times the index.
package pcr_pkg;
  localparam logic [15:0] PCR_FLAGS_OFF = 16'hc000;
  localparam logic [15:0] PCR_SPEED_OFF = 16'hc008;
  localparam logic [15:0] PCR_IEN_OFF = 16'hc00e;
  localparam logic [15:0] PCR_BRK_OFF = 16'hc014;
  localparam logic [15:0] PCR_MDIAG_OFF = 16'hc03e;
  localparam logic [3:0] PCR_SPEED_RST = 4'hf;
  localparam logic [7:0] PCR_IEN_RST = 8'h00;
  localparam logic [15:0] PCR_BRK_RST = 16'h0000;
  localparam int PCR_SPEED_W = 4;
  localparam int PCR_ARB_LO = 8;
  localparam int PCR_ARB_HI = 10;
  localparam int PCR_MON_BIT = 0;
  localparam int PCR_IEN_TIMER0 = 0;
  localparam int PCR_IEN_TIMER1 = 1;
  localparam int PCR_IEN_GPIO = 2;
  localparam int PCR_IEN_UART = 3;
  localparam int PCR_IEN_OBX = 5;
  localparam int PCR_IEN_IBX = 6;
  localparam int PCR_IEN_FSP = 7;
  localparam int PCR_FLG_ZERO = 0;
  localparam int PCR_FLG_CARRY = 1;
  localparam int PCR_FLG_OVF = 2;
  localparam logic [2:0] PCR_ARB_LAST = 3'h7;
  localparam logic [6:0] PCR_BRK_VECTOR = 7'h7f;

  // Interrupt sources from peripherals, one-cycle request pulses
  typedef struct packed {
    logic fsp_block_done;
    logic fsp_rx_full;
    logic inbox;
    logic outbox;
    logic uart_tx;
    logic uart_rx;
    logic gpio;
    logic timer1;
    logic timer0;
  } pcr_irq_src_type;

  // Result status from the processor ALU, valid with a strobe
  typedef struct packed {
    logic valid;
    logic carry;
    logic zero;
    logic overflow;
  } pcr_alu_type;
endpackage : pcr_pkg

// ==== rtl/pcr_clk_div.sv ====
// Processor clock-enable divider.
// Assumes one system clock; divisor is steady between boundaries.
`timescale 1ns/1ns
module pcr_clk_div
  import pcr_pkg::*;
#(
  parameter int W = PCR_SPEED_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] divisor,
  output logic cpu_en
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] div_r;

  // Enable pulse, not a derived clock, to avoid gated-clock glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      div_r <= W'(PCR_SPEED_RST);
      cpu_en <= 1'b0;
    end else if (cnt_r >= div_r) begin
      cnt_r <= '0;
      div_r <= divisor;
      cpu_en <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      cpu_en <= 1'b0;
    end
  end

  cpu_en_single_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cpu_en && div_r != '0 |=> !cpu_en)
    else $error("cpu enable held more than one cycle");
endmodule : pcr_clk_div

// ==== rtl/pcr_regs.sv ====
// Processor control register group: flags, speed divisor, interrupt
// enables with pending latches, breakpoint match, memory diagnostics.
// Assumes an APB master on pclk and single-cycle source pulses.
//
// Function
// - Carry flag bit 1 tracks carry/borrow
// - Zero flag bit 0 tracks zero result
// - Speed field divides processor clock by n+1
// - Divisor slows only the processor
// - Bit 7 gates both fast serial interrupts
// - Bit 6 gates inbox interrupt
// - Bit 5 gates outbox interrupt
// - Bit 3 gates both UART interrupts
// - Bit 2 gates GPIO, clearing drops pending
// - Bit 1 gates second timer, drops pending
// - Bit 0 gates first timer, drops pending
// - Program counter match raises vector 127
// - Writing zero to breakpoint clears interrupt
// - Arbitration code leaves 8-code of 8 cycles
// - Monitor bit echoes internal address out
// - Memory diagnostic register is write-only
// - Overflow flag bit 2 tracks range overflow
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns
module pcr_regs
  import pcr_pkg::*;
#(
  parameter int AW = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pcr_alu_type alu,
  input wire logic [15:0] cpu_pc,
  input wire logic pc_valid,
  input wire logic [15:0] int_addr,
  input wire pcr_irq_src_type irq_src,
  input wire logic [8:0] irq_ack,
  output logic [8:0] irq_pend_r,
  output logic brk_irq_r,
  output logic [6:0] brk_vector_r,
  output logic cpu_en_r,
  output logic mem_slot_r,
  output logic [15:0] ext_addr_r,
  output logic ext_addr_oe_r
);
  logic [2:0] flags_r;
  logic [PCR_SPEED_W-1:0] speed_r;
  logic [7:0] ien_r;
  logic [15:0] brk_r;
  logic [2:0] arb_r;
  logic mon_r;
  logic [2:0] slot_r;
  logic cpu_en;
  logic wr_acc;
  logic rd_acc;
  logic [8:0] gate;
  logic [8:0] src;

  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [15:0] off);
    hit = (a == {off, 2'b00});
  endfunction : hit

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  // Zero-wait slave: pready always high after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
    end
  end

  // Unmapped addresses, flags writes and reads of the write-only register error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= !(hit(paddr, PCR_FLAGS_OFF) || hit(paddr, PCR_SPEED_OFF)
        || hit(paddr, PCR_IEN_OFF) || hit(paddr, PCR_BRK_OFF)
        || (hit(paddr, PCR_MDIAG_OFF) && pwrite))
        || (hit(paddr, PCR_FLAGS_OFF) && pwrite);
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  // Read data set up in the setup cycle, valid in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_acc) begin
      prdata <= '0;
      if (hit(paddr, PCR_FLAGS_OFF))
        prdata[2:0] <= flags_r;
      else if (hit(paddr, PCR_SPEED_OFF))
        prdata[PCR_SPEED_W-1:0] <= speed_r;
      else if (hit(paddr, PCR_IEN_OFF))
        prdata[7:0] <= ien_r;
      else if (hit(paddr, PCR_BRK_OFF))
        prdata[15:0] <= brk_r;
    end
  end

  // Condition flags follow each retired ALU result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= '0;
    end else if (alu.valid) begin
      flags_r[PCR_FLG_ZERO] <= alu.zero;
      flags_r[PCR_FLG_CARRY] <= alu.carry;
      flags_r[PCR_FLG_OVF] <= alu.overflow;
    end
  end

  // Reserved bits dropped; software is expected to write them zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_r <= PCR_SPEED_RST;
    end else if (wr_acc && hit(paddr, PCR_SPEED_OFF)) begin
      speed_r <= pwdata[PCR_SPEED_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_r <= PCR_IEN_RST;
    end else if (wr_acc && hit(paddr, PCR_IEN_OFF)) begin
      ien_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_r <= '0;
      mon_r <= 1'b0;
    end else if (wr_acc && hit(paddr, PCR_MDIAG_OFF)) begin
      arb_r <= pwdata[PCR_ARB_HI:PCR_ARB_LO];
      mon_r <= pwdata[PCR_MON_BIT];
    end
  end

  // Divider feeds only the processor enable; slots use pclk directly
  pcr_clk_div #(.W(PCR_SPEED_W)) pcr_clk_div_i (
    .pclk(pclk),
    .presetn(presetn),
    .divisor(speed_r),
    .cpu_en(cpu_en)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_en_r <= 1'b0;
    end else begin
      cpu_en_r <= cpu_en;
    end
  end

  // Gate map: fsp_blk, fsp_rx, inbox, outbox, utx, urx, gpio, timer1, timer0
  assign gate = {ien_r[PCR_IEN_FSP], ien_r[PCR_IEN_FSP],
                 ien_r[PCR_IEN_IBX],
                 ien_r[PCR_IEN_OBX],
                 ien_r[PCR_IEN_UART], ien_r[PCR_IEN_UART],
                 ien_r[PCR_IEN_GPIO],
                 ien_r[PCR_IEN_TIMER1],
                 ien_r[PCR_IEN_TIMER0]};
  assign src = irq_src;

  // Pending latch per source; set beats ack, disable wipes it
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi++) begin : g_pend
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          irq_pend_r[gi] <= 1'b0;
        end else if (!gate[gi]) begin
          irq_pend_r[gi] <= 1'b0;
        end else if (src[gi]) begin
          irq_pend_r[gi] <= 1'b1;
        end else if (irq_ack[gi]) begin
          irq_pend_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Breakpoint: zero write clears, match sets; match wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_r <= PCR_BRK_RST;
    end else if (wr_acc && hit(paddr, PCR_BRK_OFF)) begin
      brk_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_irq_r <= 1'b0;
    end else if (pc_valid && cpu_pc == brk_r) begin
      brk_irq_r <= 1'b1;
    end else if (wr_acc && hit(paddr, PCR_BRK_OFF)
                 && pwdata[15:0] == '0) begin
      brk_irq_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_vector_r <= '0;
    end else begin
      brk_vector_r <= PCR_BRK_VECTOR;
    end
  end

  // Arbitration: slots 0..7; slot < 8-code is live
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_r <= '0;
    end else begin
      slot_r <= slot_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_slot_r <= 1'b0;
    end else begin
      mem_slot_r <= (slot_r <= (PCR_ARB_LAST - arb_r));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_addr_r <= '0;
      ext_addr_oe_r <= 1'b0;
    end else begin
      ext_addr_r <= mon_r ? int_addr : '0;
      ext_addr_oe_r <= mon_r;
    end
  end

  // Zero write that no same-cycle match overrides
  logic brk_zero_wr;
  assign brk_zero_wr = wr_acc && hit(paddr, PCR_BRK_OFF)
    && pwdata[15:0] == '0 && !(pc_valid && cpu_pc == brk_r);

  sequence brk_match_s;
    pc_valid && cpu_pc == brk_r;
  endsequence

  sequence brk_zero_wr_s;
    brk_zero_wr;
  endsequence

  brk_raise_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    brk_match_s |=> brk_irq_r)
    else $error("breakpoint match did not raise interrupt");

  brk_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    brk_zero_wr_s |=> !brk_irq_r)
    else $error("zero breakpoint write did not clear");

  brk_vector_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    brk_irq_r |-> brk_vector_r == PCR_BRK_VECTOR)
    else $error("breakpoint vector wrong");

  gpio_drop_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ien_r[PCR_IEN_GPIO] |=> !irq_pend_r[2])
    else $error("gpio pending kept while disabled");

  timer1_drop_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ien_r[PCR_IEN_TIMER1] |=> !irq_pend_r[1])
    else $error("timer1 pending kept while disabled");

  timer0_drop_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ien_r[PCR_IEN_TIMER0] |=> !irq_pend_r[0])
    else $error("timer0 pending kept while disabled");

  timer0_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ien_r[PCR_IEN_TIMER0] && irq_src.timer0 |=> irq_pend_r[0])
    else $error("timer0 request lost");

  fsp_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ien_r[PCR_IEN_FSP] |=> irq_pend_r[8:7] == 2'b00)
    else $error("fast serial request passed while disabled");

  inbox_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ien_r[PCR_IEN_IBX] |=> !irq_pend_r[6])
    else $error("inbox request passed while disabled");

  outbox_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ien_r[PCR_IEN_OBX] |=> !irq_pend_r[5])
    else $error("outbox request passed while disabled");

  uart_gate_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ien_r[PCR_IEN_UART] |=> irq_pend_r[4:3] == 2'b00)
    else $error("uart request passed while disabled");

  flag_track_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    alu.valid |=> flags_r == {$past(alu.overflow), $past(alu.carry),
                              $past(alu.zero)})
    else $error("flags did not follow alu result");

  diag_read_err_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && hit(paddr, PCR_MDIAG_OFF)
    |=> pslverr && prdata == '0)
    else $error("write-only register read not refused");

  slot_first_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    slot_r == '0 |=> mem_slot_r)
    else $error("first memory slot not live");

  slot_last_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    slot_r == PCR_ARB_LAST && arb_r != '0 |=> !mem_slot_r)
    else $error("last memory slot not dead");

  slot_free_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> slot_r == $past(slot_r) + 3'h1)
    else $error("memory slots not on system clock");

  mon_echo_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    mon_r |=> ext_addr_oe_r && ext_addr_r == $past(int_addr))
    else $error("monitor echo missing");

  mon_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !mon_r |=> !ext_addr_oe_r && ext_addr_r == '0)
    else $error("address driven with monitor off");
endmodule : pcr_regs

// ==== testbench/pcr_core_model.sv ====
// Processor core and interrupt sources facing the register group.
// Assumes callers enter its tasks just after a rising edge.
`timescale 1ns/1ns
module pcr_core_model
  import pcr_pkg::*;
(
  input wire logic pclk,
  output pcr_alu_type alu,
  output logic [15:0] cpu_pc,
  output logic pc_valid,
  output logic [15:0] int_addr,
  output pcr_irq_src_type irq_src,
  output logic [8:0] irq_ack
);
  logic [17:0] tick = 18'h00000;
  initial begin
    alu = '0;
    cpu_pc = 16'hffff;
    pc_valid = 1'b0;
    irq_src = '0;
    irq_ack = 9'h000;
  end
  // Address moves every 4 cycles so the echo is seen settled
  always @(posedge pclk) tick <= tick + 18'h00001;
  assign int_addr = tick[17:2] ^ 16'ha5c3;
  task automatic alu_op(input logic c, input logic z, input logic o);
    alu <= {1'b1, c, z, o};
    @(posedge pclk);
    alu <= '0;
  endtask : alu_op
  task automatic pc_hit(input logic [15:0] pc);
    cpu_pc <= pc;
    pc_valid <= 1'b1;
    @(posedge pclk);
    pc_valid <= 1'b0;
    cpu_pc <= ~pc; // Stale value never left standing
  endtask : pc_hit
  task automatic pulse(input logic [8:0] s, input logic [8:0] a);
    irq_src <= s;
    irq_ack <= a;
    @(posedge pclk);
    irq_src <= '0;
    irq_ack <= 9'h000;
  endtask : pulse
endmodule : pcr_core_model

// ==== testbench/processor_control_regs_bench.sv ====
// Self-checking bench for the processor control register group.
// Assumes one 25 MHz clock and a zero-wait APB slave.
`timescale 1ns/1ns
module processor_control_regs_bench;
  import pcr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, brk_irq_r, cpu_en_r, mem_slot_r, ext_addr_oe_r, e;
  logic [6:0] brk_vector_r;
  logic [8:0] irq_pend_r, irq_ack;
  logic [15:0] cpu_pc, int_addr, ext_addr_r;
  logic pc_valid;
  pcr_alu_type alu;
  pcr_irq_src_type irq_src;
  int n_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int c;
  pcr_regs pcr_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .alu(alu),
    .cpu_pc(cpu_pc), .pc_valid(pc_valid), .int_addr(int_addr),
    .irq_src(irq_src), .irq_ack(irq_ack), .irq_pend_r(irq_pend_r),
    .brk_irq_r(brk_irq_r), .brk_vector_r(brk_vector_r),
    .cpu_en_r(cpu_en_r), .mem_slot_r(mem_slot_r),
    .ext_addr_r(ext_addr_r), .ext_addr_oe_r(ext_addr_oe_r));
  pcr_core_model pcr_core_model_i (.pclk(pclk), .alu(alu), .cpu_pc(cpu_pc),
    .pc_valid(pc_valid), .int_addr(int_addr), .irq_src(irq_src),
    .irq_ack(irq_ack));
  initial begin
    forever #20 pclk = ~pclk;
  end
  task automatic conclude;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  // Whole run needs about 2000 cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      n_errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, s, x);
    end
  endtask : chk
  // Register index a sits at byte address four times a
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk({31'h0, e}, 32'h0);
  endtask : wr
  task automatic hi_count(input logic slot);
    c = 0;
    repeat (240) begin
      @(posedge pclk);
      c += slot ? int'(mem_slot_r) : int'(cpu_en_r);
    end
  endtask : hi_count
  function automatic logic [8:0] gate(input logic [7:0] n);
    gate = {n[7], n[7], n[6], n[5], n[3], n[3], n[2], n[1], n[0]};
  endfunction : gate
  task automatic t_reset;
    apb(1'b0, PCR_SPEED_OFF, 32'h0);
    chk(q, 32'h0000000f);
    apb(1'b0, PCR_BRK_OFF, 32'h0);
    chk(q, 32'h0);
    chk({25'h0, brk_vector_r}, 32'h0000007f);
    apb(1'b0, PCR_MDIAG_OFF, 32'h0);
    chk({q[31:1], e}, 32'h1);
    apb(1'b1, 16'hc002, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_flags;
    for (int i = 0; i < 8; i++) begin
      pcr_core_model_i.alu_op(i[1], i[0], i[2]);
      apb(1'b0, PCR_FLAGS_OFF, 32'h0);
      chk(q, {29'h0, i[2:0]});
    end
    $display("flags test done");
  endtask : t_flags
  task automatic t_speed;
    logic [3:0] sp[4] = '{4'h0, 4'h3, 4'h4, 4'hf};
    foreach (sp[k]) begin
      wr(PCR_SPEED_OFF, {28'h0, sp[k]});
      repeat (40) @(posedge pclk);
      hi_count(1'b0);
      chk(c, 240 / (sp[k] + 1));
    end
    $display("speed test done");
  endtask : t_speed
  task automatic t_irq;
    logic [7:0] n;
    for (int b = 0; b < 8; b++) begin
      if (b != 4) begin
        n = 8'h01 << b;
        wr(PCR_IEN_OFF, {24'h0, n});
        pcr_core_model_i.pulse(9'h1ff, 9'h000);
        @(posedge pclk);
        chk(irq_pend_r, gate(n));
      end
    end
    wr(PCR_IEN_OFF, 32'h000000ef);
    pcr_core_model_i.pulse(9'h1ff, 9'h000);
    wr(PCR_IEN_OFF, 32'h00000008);
    // Pending bits drop one edge after the new enables land
    @(posedge pclk);
    chk(irq_pend_r, 9'h018);
    pcr_core_model_i.pulse(9'h000, 9'h1ff);
    @(posedge pclk);
    chk(irq_pend_r, 9'h000);
    $display("interrupt test done");
  endtask : t_irq
  task automatic t_brk;
    wr(PCR_BRK_OFF, 32'h00001234);
    pcr_core_model_i.pc_hit(16'h1233);
    @(posedge pclk);
    chk({31'h0, brk_irq_r}, 32'h0);
    pcr_core_model_i.pc_hit(16'h1234);
    @(posedge pclk);
    chk({31'h0, brk_irq_r}, 32'h1);
    apb(1'b0, PCR_BRK_OFF, 32'h0);
    chk(q, 32'h00001234);
    wr(PCR_BRK_OFF, 32'h0);
    chk({31'h0, brk_irq_r}, 32'h0);
    $display("breakpoint test done");
  endtask : t_brk
  task automatic t_diag;
    logic [2:0] cd[3] = '{3'h0, 3'h3, 3'h7};
    foreach (cd[k]) begin
      wr(PCR_MDIAG_OFF, {21'h0, cd[k], 8'h00});
      repeat (4) @(posedge pclk);
      hi_count(1'b1);
      chk(c, 30 * (8 - cd[k]));
    end
    chk({15'h0, ext_addr_oe_r, ext_addr_r}, 32'h0);
    wr(PCR_MDIAG_OFF, 32'h00000001);
    @(int_addr);
    repeat (3) @(posedge pclk);
    chk({ext_addr_oe_r, ext_addr_r}, {1'b1, int_addr});
    $display("diagnostic test done");
  endtask : t_diag
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_flags();
    t_speed();
    t_irq();
    t_brk();
    t_diag();
    conclude();
  end
endmodule : processor_control_regs_bench
